// [mote_serial_handshake_uart_tb.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("Error %s expected %h seen %h", n, e, g); \
  end \
end
module mote_serial_handshake_uart_tb;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] m_tx_data = 8'h00;
  logic m_tx_last = 1'b0;
  logic m_tx_valid = 1'b0;
  logic net_joined = 1'b1;
  logic buf_space_ok = 1'b1;
  logic [7:0] h_tx_data = 8'h00;
  logic h_tx_last = 1'b0;
  logic h_tx_valid = 1'b0;
  logic rx_enable = 1'b0;
  logic tx_net = 1'b0;
  logic late_seen = 1'b0;
  logic [7:0] h_prev = 8'h00;
  logic m_tx_ready, m_rx_valid, m_rx_err, req_timeout, ack_pending, ack_late;
  logic h_tx_ready, h_rx_valid, h_rx_err;
  logic [7:0] m_rx_data, h_rx_data, ev_m, ev_h;
  logic [7:0] q_m2h[$];
  logic [7:0] q_h2m[$];
  int failures = 0;
  int comparisons = 0;
  int n;
  logic [31:0] r;

  mshu_link_if link();
  mshu_mote #(.REQ_TIMEOUT_CYC(27'd30000), .RETRY_CYC(27'd5000), .GAP_CYC(27'd20000),
    .ACK_CYC(27'd15000)) i_mshu_mote (.ref_clk(ref_clk), .nrst(nrst), .link(link),
    .tx_data(m_tx_data), .tx_last(m_tx_last), .tx_valid(m_tx_valid), .tx_ready(m_tx_ready),
    .rx_data(m_rx_data), .rx_valid(m_rx_valid), .rx_err(m_rx_err), .net_joined(net_joined),
    .buf_space_ok(buf_space_ok), .req_timeout(req_timeout), .ack_pending(ack_pending),
    .ack_late(ack_late));
  mshu_host #(.GAP_CYC(27'd20000)) i_mshu_host (.ref_clk(ref_clk), .nrst(nrst), .link(link),
    .tx_data(h_tx_data), .tx_last(h_tx_last), .tx_net(tx_net), .tx_valid(h_tx_valid),
    .tx_ready(h_tx_ready), .rx_enable(rx_enable), .rx_data(h_rx_data),
    .rx_valid(h_rx_valid), .rx_err(h_rx_err));
  mshu_monitor i_mshu_monitor (
    .ref_clk(ref_clk), .nrst(nrst), .mote_to_host(link.mote_to_host),
    .host_to_mote(link.host_to_mote), .mote_send_request_n(link.mote_send_request_n),
    .host_clear_to_send_n(link.host_clear_to_send_n),
    .mote_accept_ready_n(link.mote_accept_ready_n));

  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish;
    if (failures == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // offer a byte and hold it until taken; ready is looked at a half cycle before the edge
  task automatic send(input bit h, input logic [7:0] d, input logic last);
    @(negedge ref_clk);
    if (h) begin
      h_tx_data = d;
      h_tx_last = last;
      h_tx_valid = 1'b1;
      if (!(d == 8'h7e && h_prev == 8'h7e)) q_h2m.push_back(d);
      h_prev = d;
      while (h_tx_ready !== 1'b1) @(negedge ref_clk);
      @(negedge ref_clk);
      h_tx_valid = 1'b0;
    end else begin
      m_tx_data = d;
      m_tx_last = last;
      m_tx_valid = 1'b1;
      q_m2h.push_back(d);
      while (m_tx_ready !== 1'b1) @(negedge ref_clk);
      @(negedge ref_clk);
      m_tx_valid = 1'b0;
    end
  endtask

  // each received byte meets the oldest note; an unexpected byte meets an unknown
  always @(negedge ref_clk) begin
    // the lateness flag is a one-cycle pulse, so it is latched here
    if (ack_late === 1'b1) begin
      late_seen = 1'b1;
    end
    if (h_rx_valid === 1'b1) begin
      ev_h = q_m2h.size() > 0 ? q_m2h.pop_front() : 8'hxx;
      `CHK("host rx data", ev_h, h_rx_data)
      `CHK("host rx stop", 1'b0, h_rx_err)
    end
    if (m_rx_valid === 1'b1) begin
      ev_m = q_h2m.size() > 0 ? q_h2m.pop_front() : 8'hxx;
      `CHK("mote rx data", ev_m, m_rx_data)
      `CHK("mote rx stop", 1'b0, m_rx_err)
    end
  end

  // ------------------------------------------------
  // stimulus
  // ------------------------------------------------
  initial begin
    r = $urandom(18);
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    nrst = 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(negedge ref_clk);
      {net_joined, buf_space_ok} = 2'(i);
      tx_net = i[0];
      repeat (3) @(negedge ref_clk);
      `CHK("accept ready", 1'(i != 3), link.mote_accept_ready_n)
      `CHK("host net ready", 1'(i != 1), h_tx_ready)
    end
    // host stalls: two bytes fill the buffer, then the request times out and retries
    send(0, 8'($urandom) & 8'h3f, 1'b0);
    send(0, 8'($urandom) & 8'h3f, 1'b1);
    `CHK("buffer full", 1'b0, m_tx_ready)
    for (n = 0; n < 40000 && req_timeout !== 1'b1; n++) @(negedge ref_clk);
    `CHK("timeout", 1'b1, req_timeout)
    repeat (10) @(negedge ref_clk);
    `CHK("request dropped", 1'b1, link.mote_send_request_n)
    repeat (5010) @(negedge ref_clk);
    `CHK("request retried", 1'b0, link.mote_send_request_n)
    // grant opens while the host sends data, a flag and a doubled flag
    fork
      begin
        @(negedge ref_clk);
        rx_enable = 1'b1;
      end
      begin
        send(1, 8'($urandom) & 8'h3f, 1'b0);
        send(1, 8'h7e, 1'b0);
        send(1, 8'h7e, 1'b1);
      end
    join
    for (n = 0; n < 60000 && q_m2h.size() + q_h2m.size() > 0; n++) @(negedge ref_clk);
    // a doubled flag sent by mistake would land one 10.5-bit host byte later, after this 22000-cycle wait
    repeat (22000) @(negedge ref_clk);
    `CHK("bytes left", 0, q_m2h.size() + q_h2m.size())
    `CHK("ack pending", 1'b1, ack_pending)
    `CHK("ack late", 1'b1, late_seen)
    tally_and_finish();
  end

  initial begin
    #600000;
    failures++;
    tally_and_finish();
  end
endmodule

// [mshu_host.sv]
`timescale 1ns/1ps
module mshu_host #(
  parameter logic [mshu_pkg::CNT_W-1:0] GAP_CYC = mshu_pkg::GAP_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // link to the mote
  mshu_link_if.host link,
  // bytes to send; tx_net marks a packet bound for the network
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_net,
  input wire logic tx_valid,
  output logic tx_ready,
  // bytes received from the mote
  input wire logic rx_enable,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_err
);
  import mshu_pkg::*;

  mshu_host_t s;
  mshu_host_t n;
  logic take;
  logic drop;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // a packet opens only after the gap, and network ones only when accepted
  assign tx_ready = (s.tst == HT_IDLE) &&
    (!s.pkt_start || (s.gap == '0 && (!tx_net || !s.ar_s2)));
  assign take = tx_valid && tx_ready;
  assign drop = (tx_data == FLAG_BYTE) && s.last_flag;

  always_comb begin
    n = s;
    n.rvalid = 1'b0;
    n.req_s1 = link.mote_send_request_n;
    n.req_s2 = s.req_s1;
    n.ar_s1 = link.mote_accept_ready_n;
    n.ar_s2 = s.ar_s1;
    n.rx_s1 = link.mote_to_host;
    n.rx_s2 = s.rx_s1;
    if (s.gap != '0) begin
      n.gap = s.gap - 1'b1;
    end

    // transmitter, 1.5 stop bits
    unique case (s.tst)
      HT_IDLE: begin
        if (take) begin
          n.pkt_start = tx_last;
          if (tx_last) begin
            n.gap = GAP_CYC;
          end
          if (!drop) begin
            n.tst = HT_SEND;
            n.tsh = {1'b1, tx_data, 1'b0};
            n.last_flag = (tx_data == FLAG_BYTE);
            n.bcnt = '0;
            n.bidx = '0;
          end
        end
      end
      HT_SEND: begin
        if (s.bcnt == ((s.bidx == STOP_IDX) ? HOST_STOP_CYC : BIT_CYC) - 1'b1) begin
          n.bcnt = '0;
          n.tsh = {1'b1, s.tsh[9:1]};
          if (s.bidx == STOP_IDX) begin
            n.tst = HT_IDLE;
          end else begin
            n.bidx = s.bidx + 1'b1;
          end
        end else begin
          n.bcnt = s.bcnt + 1'b1;
        end
      end
      default: begin
        n.tst = HT_IDLE;
      end
    endcase
    n.pin_tx = (n.tst == HT_SEND) ? n.tsh[0] : 1'b1;

    // grant a session as soon as the mote asks and we can take bytes
    if (!s.sess && !s.req_s2 && rx_enable) begin
      n.sess = 1'b1;
      n.sseen = 1'b0;
      n.cts_n = 1'b0;
    end else if (s.cts_n && s.pw != 8'h0) begin
      n.pw = s.pw - 1'b1;
    end else if (s.sess && s.cts_n && rx_enable) begin
      n.cts_n = 1'b0;
    end

    // receiver; the grant drops at the stop sample, 9.5 bits after start
    if (!s.rbusy) begin
      if (!s.rx_s2) begin
        n.rbusy = 1'b1;
        n.rcnt = '0;
        n.ridx = '0;
      end
    end else if (s.rcnt == ((s.ridx == 4'h0) ? HALF_BIT_CYC : BIT_CYC) - 1'b1) begin
      n.rcnt = '0;
      if (s.ridx == 4'h0) begin
        n.rbusy = !s.rx_s2;
        n.ridx = 4'h1;
      end else if (s.ridx != STOP_IDX) begin
        n.rsh = {s.rx_s2, s.rsh[7:1]};
        n.ridx = s.ridx + 1'b1;
      end else begin
        n.rbusy = 1'b0;
        n.rvalid = 1'b1;
        n.rerr = !s.rx_s2;
        n.rdata = s.rsh;
        n.cts_n = 1'b1;
        n.pw = ACK_PW_CYC;
        if (s.rsh == FLAG_BYTE && s.sseen) begin
          n.sess = 1'b0; // closing flag ends the session
        end else if (s.rsh != FLAG_BYTE) begin
          n.sseen = 1'b1;
        end
      end
    end else begin
      n.rcnt = s.rcnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s <= HOST_RST;
    end else begin
      s <= n;
    end
  end

  assign link.host_to_mote = s.pin_tx;
  assign link.host_clear_to_send_n = s.cts_n;
  assign rx_data = s.rdata;
  assign rx_valid = s.rvalid;
  assign rx_err = s.rerr;
endmodule

// [mshu_link_if.sv]
`timescale 1ns/1ps
// five wires between the mote and the host; all handshake lines are active low
interface mshu_link_if;
  logic mote_to_host;
  logic host_to_mote;
  logic mote_send_request_n;
  logic host_clear_to_send_n;
  logic mote_accept_ready_n;

  modport mote (
    output mote_to_host,
    output mote_send_request_n,
    output mote_accept_ready_n,
    input host_to_mote,
    input host_clear_to_send_n
  );

  modport host (
    input mote_to_host,
    input mote_send_request_n,
    input mote_accept_ready_n,
    output host_to_mote,
    output host_clear_to_send_n
  );
endinterface

// [mshu_monitor.sv]
`timescale 1ns/1ps
// watches the five link wires where both ends are design code
module mshu_monitor #(
  parameter int REQ_TIMEOUT_CYC = 30000,
  parameter int RETRY_CYC = 5000
) (
  // clock and reset
  input logic ref_clk,
  input logic nrst,
  // link wires
  input logic mote_to_host,
  input logic host_to_mote,
  input logic mote_send_request_n,
  input logic host_clear_to_send_n,
  input logic mote_accept_ready_n
);
  localparam int BIT = 2170;
  localparam int IDLE = 20615; // mid stop bit
  localparam int LIM = 2000000;
  localparam int PW = 125; // grant pulse floor in cycles
  localparam int INTERBYTE = 1775000; // regrant ceiling after a byte start, in cycles
  int since_reg;
  int lo_reg;
  int hi_reg;
  int ghi_reg;
  logic to_reg;
  logic regr_reg;
  logic line_reg;
  logic start;

  // a fall counts as a byte start only past mid stop, so data bits never restart it
  assign start = line_reg && !mote_to_host && since_reg >= IDLE;

  // since_reg saturates: a long idle must not wrap into a start window
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      since_reg <= LIM;
      lo_reg <= 0;
      hi_reg <= 0;
      ghi_reg <= PW;
      to_reg <= 1'b0;
      regr_reg <= 1'b0;
      line_reg <= 1'b1;
    end else begin
      since_reg <= start ? 0 : (since_reg < LIM ? since_reg + 1 : since_reg);
      lo_reg <= mote_send_request_n ? 0 : lo_reg + 1;
      hi_reg <= mote_send_request_n ? hi_reg + 1 : 0;
      ghi_reg <= host_clear_to_send_n ? ghi_reg + 1 : 0;
      line_reg <= mote_to_host;
      to_reg <= mote_send_request_n && (to_reg || (lo_reg != 0 && host_clear_to_send_n));
      regr_reg <= !start && (regr_reg || $fell(host_clear_to_send_n));
    end
  end

  // ------------------------------------------------
  // checks
  // ------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  property p_req_drop;
    $fell(host_clear_to_send_n) && !mote_send_request_n |-> ##[1:4] mote_send_request_n;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("request held after grant");
  property p_first_start;
    $fell(host_clear_to_send_n) && !mote_send_request_n |-> ##[1:4] start;
  endproperty
  a_first_start: assert property (p_first_start) else $error("no start bit");
  property p_req_hold;
    $rose(mote_send_request_n) |-> !host_clear_to_send_n || lo_reg + 2 >= REQ_TIMEOUT_CYC;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped early");
  property p_req_limit;
    !mote_send_request_n |-> lo_reg <= REQ_TIMEOUT_CYC + 2;
  endproperty
  a_req_limit: assert property (p_req_limit) else $error("request never timed out");
  property p_retry;
    to_reg && mote_send_request_n |-> hi_reg <= RETRY_CYC + 2;
  endproperty
  a_retry: assert property (p_retry) else $error("retry late");
  property p_grant_pw;
    $fell(host_clear_to_send_n) |-> ghi_reg >= PW;
  endproperty
  a_grant_pw: assert property (p_grant_pw) else $error("grant pulse short");
  property p_grant_hold;
    $rose(host_clear_to_send_n) |-> since_reg >= BIT;
  endproperty
  a_grant_hold: assert property (p_grant_hold) else $error("grant negated early");
  property p_byte_grant;
    start |-> regr_reg;
  endproperty
  a_byte_grant: assert property (p_byte_grant) else $error("byte without grant");
  property p_start_len;
    since_reg == BIT * 99 / 100 |-> !mote_to_host;
  endproperty
  a_start_len: assert property (p_start_len) else $error("start bit short");
  property p_stop;
    since_reg == IDLE |-> mote_to_host;
  endproperty
  a_stop: assert property (p_stop) else $error("stop bit low");
  // only regrants count: the first grant of a session follows no byte
  property p_interbyte;
    $fell(host_clear_to_send_n) && mote_send_request_n |-> since_reg <= INTERBYTE;
  endproperty
  a_interbyte: assert property (p_interbyte) else $error("regrant late");

  c_timeout: cover property ($rose(mote_send_request_n) && host_clear_to_send_n);
  c_regrant: cover property (start && regr_reg);
  c_grant: cover property ($fell(host_clear_to_send_n));
  c_accept: cover property ($fell(mote_accept_ready_n));
  c_host_byte: cover property ($fell(host_to_mote));
endmodule

// [mshu_mote.sv]
`timescale 1ns/1ps
// Contract
// - host rate within 2 percent, mote 1 percent
// - host 1/1.5 stop bits, mote one
// - drop request within 10 ms of grant
// - host grants within 500 ms or timeout
// - retry request within 500 ms of timeout
// - start byte within 10 ms of grant
// - host holds grant one bit after start
// - host grant negation pulse at least 500 ns
// - mote answers every request within 125 ms
// - host negates grant within 7.1 ms
// - senders wait 20 ms between packets; the host starts its gap when it takes the last byte, not after sending it
// - host never doubles the opening flag
// - request held low until grant or timeout
// - grant negated, reasserted per byte; then send
// - accept-ready high when off network or full
module mshu_mote #(
  parameter logic [mshu_pkg::CNT_W-1:0] REQ_TIMEOUT_CYC = mshu_pkg::REQ_TIMEOUT_CYC,
  parameter logic [mshu_pkg::CNT_W-1:0] RETRY_CYC = mshu_pkg::RETRY_CYC,
  parameter logic [mshu_pkg::CNT_W-1:0] GAP_CYC = mshu_pkg::GAP_CYC,
  parameter logic [mshu_pkg::CNT_W-1:0] ACK_CYC = mshu_pkg::ACK_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // link to the host
  mshu_link_if.mote link,
  // bytes to send, one packet ends at tx_last
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_valid,
  output logic tx_ready,
  // bytes received from the host
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_err,
  // network and buffer status
  input wire logic net_joined,
  input wire logic buf_space_ok,
  // status
  output logic req_timeout,
  output logic ack_pending,
  output logic ack_late
);
  import mshu_pkg::*;

  mshu_mote_t s;
  mshu_mote_t n;
  logic push;
  logic pop;
  logic cts_on;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  assign tx_ready = (s.fcnt != 2'd2); // the two-entry buffer stalls the source
  assign push = tx_valid && tx_ready;
  assign cts_on = !s.cts_s2;

  always_comb begin
    n = s;
    pop = 1'b0;
    n.req_to = 1'b0;
    n.rvalid = 1'b0;
    n.ack_late = 1'b0;
    // pin synchronisers
    n.cts_s1 = link.host_clear_to_send_n;
    n.cts_s2 = s.cts_s1;
    n.rx_s1 = link.host_to_mote;
    n.rx_s2 = s.rx_s1;
    n.ar_n = !(net_joined && buf_space_ok);
    if (s.gap != '0) begin
      n.gap = s.gap - 1'b1;
    end

    // transmit sequencer
    unique case (s.tst)
      MT_IDLE: begin
        if (s.fcnt != 2'd0 && s.gap == '0) begin
          n.tst = MT_REQ;
          n.req_n = 1'b0;
          n.tcnt = '0;
          n.ack_pend = 1'b0;
        end
      end
      MT_REQ: begin
        if (cts_on) begin
          n.req_n = 1'b1;
          n.tst = MT_SEND;
          n.tsh = {1'b1, s.fbuf[0][7:0], 1'b0};
          n.tlast = s.fbuf[0][8];
          n.bcnt = '0;
          n.bidx = '0;
          n.neg_seen = 1'b0;
        end else if (s.tcnt == REQ_TIMEOUT_CYC - 1'b1) begin
          n.req_n = 1'b1;
          n.req_to = 1'b1;
          n.tcnt = '0;
          n.tst = MT_RETRY;
        end else begin
          n.tcnt = s.tcnt + 1'b1;
        end
      end
      MT_RETRY: begin
        if (s.tcnt == RETRY_CYC - 1'b1) begin
          n.req_n = 1'b0;
          n.tcnt = '0;
          n.tst = MT_REQ;
        end else begin
          n.tcnt = s.tcnt + 1'b1;
        end
      end
      MT_SEND: begin
        // the host may negate and reassert before our stop bit ends
        if (!cts_on) begin
          n.neg_seen = 1'b1;
        end
        if (s.bcnt == BIT_CYC - 1'b1) begin
          n.bcnt = '0;
          n.tsh = {1'b1, s.tsh[9:1]};
          if (s.bidx == STOP_IDX) begin
            pop = 1'b1;
            if (s.tlast) begin
              n.gap = GAP_CYC;
              n.tst = MT_IDLE;
            end else begin
              n.tst = MT_WAIT;
            end
          end else begin
            n.bidx = s.bidx + 1'b1;
          end
        end else begin
          n.bcnt = s.bcnt + 1'b1;
        end
      end
      MT_WAIT: begin
        if (!cts_on) begin
          n.neg_seen = 1'b1;
        end
        if ((s.neg_seen || !cts_on) && cts_on && s.fcnt != 2'd0) begin
          n.tst = MT_SEND;
          n.tsh = {1'b1, s.fbuf[0][7:0], 1'b0};
          n.tlast = s.fbuf[0][8];
          n.bcnt = '0;
          n.bidx = '0;
          n.neg_seen = 1'b0;
        end
      end
    endcase
    n.pin_tx = (n.tst == MT_SEND) ? n.tsh[0] : 1'b1;

    // two-entry buffer: pop shifts the head out, push lands behind it
    if (pop) begin
      n.fbuf[0] = s.fbuf[1];
      n.fcnt = s.fcnt - 1'b1;
    end
    if (push) begin
      n.fbuf[n.fcnt[0]] = {tx_last, tx_data};
      n.fcnt = n.fcnt + 1'b1;
    end

    // receiver samples mid-bit, leaving room for host rate error
    if (!s.rbusy) begin
      if (!s.rx_s2) begin
        n.rbusy = 1'b1;
        n.rcnt = '0;
        n.ridx = '0;
      end
    end else if (s.rcnt == ((s.ridx == 4'h0) ? HALF_BIT_CYC : BIT_CYC) - 1'b1) begin
      n.rcnt = '0;
      if (s.ridx == 4'h0) begin
        n.rbusy = !s.rx_s2;
        n.ridx = 4'h1;
      end else if (s.ridx != STOP_IDX) begin
        n.rsh = {s.rx_s2, s.rsh[7:1]};
        n.ridx = s.ridx + 1'b1;
      end else begin
        // one stop bit is all we check, so 1.5 from the host also passes
        n.rbusy = 1'b0;
        n.rvalid = 1'b1;
        n.rerr = !s.rx_s2;
        n.rdata = s.rsh;
        // a lone flag both ends one packet and opens the next
        if (s.rsh == FLAG_BYTE && s.rseen) begin
          n.rseen = 1'b0;
          n.ack_pend = 1'b1;
          n.ack_cnt = ACK_CYC;
        end else if (s.rsh != FLAG_BYTE) begin
          n.rseen = 1'b1;
        end
      end
    end else begin
      n.rcnt = s.rcnt + 1'b1;
    end

    // answer watchdog: flags a reply that is late, user must queue one
    if (s.ack_pend && s.ack_cnt != '0) begin
      n.ack_cnt = s.ack_cnt - 1'b1;
      if (s.ack_cnt == CNT_W'(1)) begin
        n.ack_late = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s <= MOTE_RST;
    end else begin
      s <= n;
    end
  end

  // pins and user outputs all come from the state register
  assign link.mote_to_host = s.pin_tx;
  assign link.mote_send_request_n = s.req_n;
  assign link.mote_accept_ready_n = s.ar_n;
  assign rx_data = s.rdata;
  assign rx_valid = s.rvalid;
  assign rx_err = s.rerr;
  assign req_timeout = s.req_to;
  assign ack_pending = s.ack_pend;
  assign ack_late = s.ack_late;
endmodule

// [mshu_pkg.sv]
package mshu_pkg;

  // ----------------------------------------------------------------
  // clock and link timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 250000; // ref_clk rate
  localparam int BAUD_BPS = 115200;
  localparam int CNT_W = 27; // wide enough for the longest wait
  localparam logic [11:0] BIT_CYC = 12'((CLK_KHZ * 1000 + BAUD_BPS / 2) / BAUD_BPS);
  localparam logic [11:0] HALF_BIT_CYC = 12'(BIT_CYC / 2);
  localparam int HOST_STOP_HALVES = 3; // 1.5 stop bits from the host
  localparam logic [11:0] HOST_STOP_CYC = 12'(HOST_STOP_HALVES * HALF_BIT_CYC);
  localparam logic [3:0] STOP_IDX = 4'h9;
  localparam logic [7:0] FLAG_BYTE = 8'h7e;

  // printed times, each in its own unit
  localparam int T_REQ_TIMEOUT_MS = 500;
  localparam int T_RETRY_MS = 100; // below the 500 ms ceiling
  localparam int T_INTERPACKET_MS = 20;
  localparam int T_ACK_TIMEOUT_MS = 125;
  localparam int T_ACK_PW_NS = 500;

  // derived cycle counts (least times round up, longest round down)
  localparam logic [CNT_W-1:0] REQ_TIMEOUT_CYC = CNT_W'(T_REQ_TIMEOUT_MS * CLK_KHZ);
  localparam logic [CNT_W-1:0] RETRY_CYC = CNT_W'(T_RETRY_MS * CLK_KHZ);
  localparam logic [CNT_W-1:0] GAP_CYC = CNT_W'(T_INTERPACKET_MS * CLK_KHZ);
  localparam logic [CNT_W-1:0] ACK_CYC = CNT_W'(T_ACK_TIMEOUT_MS * CLK_KHZ);
  localparam logic [7:0] ACK_PW_CYC = 8'((T_ACK_PW_NS * (CLK_KHZ / 1000) + 999) / 1000);

  // ----------------------------------------------------------------
  // state of each end
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {MT_IDLE, MT_REQ, MT_RETRY, MT_SEND, MT_WAIT} mshu_mtx_st_t;
  typedef enum logic [1:0] {HT_IDLE, HT_SEND} mshu_htx_st_t;

  typedef struct packed {
    mshu_mtx_st_t tst;
    logic [CNT_W-1:0] tcnt;
    logic [CNT_W-1:0] gap;
    logic [11:0] bcnt;
    logic [3:0] bidx;
    logic [9:0] tsh;
    logic tlast;
    logic neg_seen;
    logic req_n;
    logic pin_tx;
    logic ar_n;
    logic req_to;
    logic [1:0][8:0] fbuf;
    logic [1:0] fcnt;
    logic rbusy;
    logic [11:0] rcnt;
    logic [3:0] ridx;
    logic [7:0] rsh;
    logic [7:0] rdata;
    logic rvalid;
    logic rerr;
    logic rseen;
    logic [CNT_W-1:0] ack_cnt;
    logic ack_pend;
    logic ack_late;
    logic cts_s1;
    logic cts_s2;
    logic rx_s1;
    logic rx_s2;
  } mshu_mote_t;

  localparam mshu_mote_t MOTE_RST = '{tst: MT_IDLE, req_n: 1'b1, pin_tx: 1'b1, ar_n: 1'b1,
    cts_s1: 1'b1, cts_s2: 1'b1, rx_s1: 1'b1, rx_s2: 1'b1, default: '0};

  typedef struct packed {
    mshu_htx_st_t tst;
    logic [CNT_W-1:0] gap;
    logic [11:0] bcnt;
    logic [3:0] bidx;
    logic [9:0] tsh;
    logic tlast;
    logic pkt_start;
    logic last_flag;
    logic pin_tx;
    logic cts_n;
    logic [7:0] pw;
    logic sess;
    logic sseen;
    logic rbusy;
    logic [11:0] rcnt;
    logic [3:0] ridx;
    logic [7:0] rsh;
    logic [7:0] rdata;
    logic rvalid;
    logic rerr;
    logic req_s1;
    logic req_s2;
    logic ar_s1;
    logic ar_s2;
    logic rx_s1;
    logic rx_s2;
  } mshu_host_t;

  localparam mshu_host_t HOST_RST = '{tst: HT_IDLE, pkt_start: 1'b1, pin_tx: 1'b1, cts_n: 1'b1,
    req_s1: 1'b1, req_s2: 1'b1, ar_s1: 1'b1, ar_s2: 1'b1, rx_s1: 1'b1, rx_s2: 1'b1,
    default: '0};

endpackage
